//--- logic/lds_pkg.sv
/*
  Constants for the link diagnostic and status block.
  Assumes a single 100 MHz clock domain and one shared management port.
*/
package lds_pkg;
  // Management register offsets (per channel bank)
  localparam logic [4:0] REG_PASS_SEL  = 5'h00;
  localparam logic [4:0] REG_CONTROL   = 5'h01;
  localparam logic [4:0] REG_DEEMPH    = 5'h05;
  localparam logic [4:0] REG_TEST_CTL  = 5'h0A;
  localparam logic [4:0] REG_LOS_CTL   = 5'h0B;
  localparam logic [4:0] REG_LOS_STAT  = 5'h0C;
  localparam logic [4:0] REG_LANE_STAT = 5'h13;
  // Field positions
  localparam int PD_BIT      = 15;
  localparam int GEN_EN_BIT  = 12;
  localparam int CHK_EN_BIT  = 13;
  localparam int PRE_LSB     = 4;
  localparam int POST_LSB    = 8;
  localparam int PASS_CH_BIT = 4;
  // Loss-of-signal control bits
  localparam int LOS_EN_BIT  = 0;
  localparam int SYNC_EN_BIT = 1;
  localparam int PLL_EN_BIT  = 2;
  localparam int DEC_EN_BIT  = 3;
  localparam int AGC_EN_BIT  = 4;
  localparam int AZ_EN_BIT   = 5;
  localparam int EQ_EN_BIT   = 6;
  // Values after reset
  localparam logic [15:0] TEST_CTL_RST = 16'h0002;
  localparam logic [15:0] ZERO16       = 16'h0000;
  // Pattern select codes
  localparam logic [2:0] PAT_PRBS7  = 3'h0;
  localparam logic [2:0] PAT_PRBS23 = 3'h1;
  localparam logic [2:0] PAT_PRBS31 = 3'h2;
  localparam logic [2:0] PAT_HF     = 3'h3;
  localparam logic [2:0] PAT_LF     = 3'h4;
  localparam logic [2:0] PAT_MF     = 3'h5;
  localparam logic [2:0] PAT_CRP_L  = 3'h6;
  localparam logic [2:0] PAT_CRP_S  = 3'h7;
  // Repeating pattern words
  localparam logic [9:0]  LF_WORD    = 10'h3E0;
  localparam logic [9:0]  MF_WORD    = 10'h3D0;
  localparam logic [19:0] CRP_L_WORD = 20'hF_35A1;
  localparam logic [19:0] CRP_S_WORD = 20'h3_C96E;
  // Lane fill sequence words and lane-down threshold
  localparam logic [9:0] FILL_W0   = 10'h17C;
  localparam logic [9:0] FILL_W1   = 10'h283;
  localparam logic [2:0] FILL_DOWN = 3'h4;
  // History depth before a checker may flag errors
  localparam logic [4:0] WARM_CYC  = 5'h1F;
  // Lane monitor states
  typedef enum logic {LDS_LANE_UP, LDS_LANE_DOWN} lds_lane_e;
endpackage

//--- logic/lds_link_diag_status.sv
/*
  Diagnostic and status logic: lane fill monitors, fill stuffing, pattern
  generators/checkers with pass pin, power-down, loss-of-signal combining.
  Assumes serial bits are presented one per clock, and status inputs come
  from logic on the same clock; only the pins are synchronised.
*/
// Functional notes
// - Eight receive monitors report lane status
// - Disconnected transmit lanes carry repeating fill
// - Low-speed PRBS 7/23/31 generate and check
// - High-speed adds HF, LF, MF, CRPAT patterns
// - Test pin enables all generators and checkers
// - Effective enable is pin OR register bits
// - PRBS31 selected after reset
// - Pass pin high clean, low on error
// - Field selects channel, side, lane for pass
// - Power-down by low pin or register bit
// - Management port keeps answering in power-down
// - Serializer outputs disabled in power-down
// - Datapath latency fixed once established
// - Two-tap de-emphasis from pre/post fields
// - Loss output active high, enable reset cleared
// - Loss indications readable through registers
// - Optionally OR sync loss into loss output
// - Optionally OR PLL unlock into loss output
// - Optionally OR 8b/10b errors into loss
// - Optionally OR gain-not-locked into loss
// - Optionally OR autozero-not-done into loss
// - Equalizer enable bit; adaptation runs itself
`timescale 1ns/1ps
module lds_link_diag_status
  import lds_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        pattern_test_enable_pin,
  input  wire logic [1:0]  channel_powerdown_pin_n,
  input  wire logic        mgmt_chan,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic [15:0] mgmt_wdata,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [79:0] rx_lane_word,
  input  wire logic        rx_word_valid,
  input  wire logic [79:0] tx_lane_word_in,
  input  wire logic [7:0]  tx_lane_present,
  input  wire logic        tx_word_valid,
  input  wire logic [1:0]  hs_rx_bit,
  input  wire logic [15:0] ls_rx_bit,
  input  wire logic [1:0]  sig_loss,
  input  wire logic [1:0]  sync_lost,
  input  wire logic [1:0]  pll_unlock,
  input  wire logic [1:0]  dec_error,
  input  wire logic [1:0]  adaptive_gain_locked,
  input  wire logic [1:0]  autozero_cal_done,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  output logic      [79:0] tx_lane_word_out,
  output logic      [1:0]  hs_tx_bit,
  output logic      [1:0]  hs_tx_oe,
  output logic      [1:0]  ls_tx_bit,
  output logic      [1:0]  ls_tx_oe,
  output logic             pattern_check_ok_pin,
  output logic             chan_a_signal_loss_out,
  output logic             chan_b_signal_loss_out,
  output logic      [7:0]  deemph_pre,
  output logic      [9:0]  deemph_post,
  output logic      [1:0]  rx_eq_enable
);

  // Next pattern bit from history; h[0] is the newest bit
  function automatic logic pat_next(input logic [30:0] h, input logic [2:0] sel);
    unique case (sel)
      PAT_PRBS7:  pat_next = h[6] ^ h[5];
      PAT_PRBS23: pat_next = h[22] ^ h[17];
      PAT_PRBS31: pat_next = h[30] ^ h[27];
      PAT_HF:     pat_next = h[1];
      PAT_LF,
      PAT_MF:     pat_next = h[9];
      PAT_CRP_L,
      PAT_CRP_S:  pat_next = h[19];
    endcase
  endfunction

  // Generator seed, phase-continuous for the repeating patterns
  function automatic logic [30:0] pat_seed(input logic [2:0] sel);
    unique case (sel)
      PAT_HF:    pat_seed = {LF_WORD[0], {3{10'h2AA}}};
      PAT_LF:    pat_seed = {LF_WORD[0], {3{LF_WORD}}};
      PAT_MF:    pat_seed = {MF_WORD[0], {3{MF_WORD}}};
      PAT_CRP_L: pat_seed = {CRP_L_WORD[10:0], CRP_L_WORD};
      PAT_CRP_S: pat_seed = {CRP_S_WORD[10:0], CRP_S_WORD};
      default:   pat_seed = {31{1'b1}};
    endcase
  endfunction

  // Low-speed side only knows the PRBS modes
  function automatic logic [2:0] ls_sel(input logic [2:0] sel);
    ls_sel = (sel > PAT_PRBS31) ? PAT_PRBS31 : sel;
  endfunction

  // Pin synchronisers: three stages, change accepted when last two agree
  logic [2:0] pin_sy_reg [3];
  logic [2:0] pin_sy_next [3];
  logic [2:0] pin_reg, pin_next;      // Filtered {pd_n[1], pd_n[0], test}

  // Per-channel management banks
  logic [15:0] pass_sel_reg [2], pass_sel_next [2];
  logic [15:0] ctrl_reg [2], ctrl_next [2];
  logic [15:0] deemph_reg [2], deemph_next [2];
  logic [15:0] test_reg [2], test_next [2];
  logic [15:0] losc_reg [2], losc_next [2];
  logic [15:0] rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;

  // Lane monitors
  lds_lane_e   lane_st_reg [8], lane_st_next [8];
  logic [2:0]  fill_cnt_reg [8], fill_cnt_next [8];
  logic [7:0]  lane_stat;

  // Fill stuffing
  logic [79:0] txw_reg, txw_next;
  logic        fill_ph_reg, fill_ph_next;

  // Pattern engines: index 0..1 high-speed, 2..3 low-speed generators
  logic [30:0] gen_reg [4], gen_next [4];
  logic [30:0] hchk_reg [2], hchk_next [2];
  logic [30:0] lchk_reg [16], lchk_next [16];
  logic [4:0]  warm_reg [2], warm_next [2];
  logic [17:0] err_reg, err_next;     // 0..15 low-speed lanes, 16..17 high-speed
  logic        pass_reg, pass_next;

  // Status and pin outputs
  logic [1:0]  los_reg, los_next, hbit_reg, hbit_next, lbit_reg, lbit_next;
  logic [1:0]  oe_reg, oe_next, eq_reg, eq_next;
  logic [7:0]  pre_reg, pre_next;
  logic [9:0]  post_reg, post_next;

  // Derived controls
  logic [1:0]  pd, test_en;
  logic [1:0]  los_raw;

  // Synchroniser and filter next values
  always_comb
  begin
    logic [2:0] raw;
    raw = {channel_powerdown_pin_n, pattern_test_enable_pin};
    pin_sy_next[0] = raw;
    pin_sy_next[1] = pin_sy_reg[0];
    pin_sy_next[2] = pin_sy_reg[1];
    pin_next = pin_reg;
    for (int i = 0; i < 3; i++)
    begin
      if (pin_sy_reg[1][i] == pin_sy_reg[2][i])
        pin_next[i] = pin_sy_reg[2][i];
    end
  end

  // Effective enables and power-down per channel
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      pd[c] = ~pin_reg[c + 1] | ctrl_reg[c][PD_BIT];
      test_en[c] = pin_reg[0] | test_reg[c][GEN_EN_BIT] | test_reg[c][CHK_EN_BIT];
    end
  end

  // Management writes and reads; not gated by power-down
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      pass_sel_next[c] = pass_sel_reg[c];
      ctrl_next[c] = ctrl_reg[c];
      deemph_next[c] = deemph_reg[c];
      test_next[c] = test_reg[c];
      losc_next[c] = losc_reg[c];
    end
    if (mgmt_wr)
    begin
      unique case (mgmt_addr)
        REG_PASS_SEL: pass_sel_next[mgmt_chan] = mgmt_wdata;
        REG_CONTROL:  ctrl_next[mgmt_chan] = mgmt_wdata;
        REG_DEEMPH:   deemph_next[mgmt_chan] = mgmt_wdata;
        REG_TEST_CTL: test_next[mgmt_chan] = mgmt_wdata;
        REG_LOS_CTL:  losc_next[mgmt_chan] = mgmt_wdata;
        default:      ;
      endcase
    end
    rvalid_next = mgmt_rd;
    rdata_next = ZERO16;
    if (mgmt_rd)
    begin
      unique case (mgmt_addr)
        REG_PASS_SEL:  rdata_next = pass_sel_reg[mgmt_chan];
        REG_CONTROL:   rdata_next = ctrl_reg[mgmt_chan];
        REG_DEEMPH:    rdata_next = deemph_reg[mgmt_chan];
        REG_TEST_CTL:  rdata_next = test_reg[mgmt_chan];
        REG_LOS_CTL:   rdata_next = losc_reg[mgmt_chan];
        // Raw conditions plus combined output
        REG_LOS_STAT:  rdata_next = {9'h000, los_reg[mgmt_chan], ~autozero_cal_done[mgmt_chan],
                                     ~adaptive_gain_locked[mgmt_chan], dec_error[mgmt_chan],
                                     pll_unlock[mgmt_chan], sync_lost[mgmt_chan],
                                     sig_loss[mgmt_chan]};
        REG_LANE_STAT: rdata_next = {8'h00, lane_stat};
        default:       rdata_next = ZERO16;
      endcase
    end
  end

  // Lane fill monitors: FILL_DOWN fill words in a row mark a lane down
  always_comb
  begin
    logic [9:0] w;
    w = 10'h000;
    for (int l = 0; l < 8; l++)
    begin
      lane_st_next[l] = lane_st_reg[l];
      fill_cnt_next[l] = fill_cnt_reg[l];
      w = rx_lane_word[l*10 +: 10];
      if (rx_word_valid)
      begin
        if (w != FILL_W0 && w != FILL_W1)
        begin
          fill_cnt_next[l] = 3'h0;
          lane_st_next[l] = LDS_LANE_UP;
        end
        else if (fill_cnt_reg[l] == FILL_DOWN - 3'h1)
          lane_st_next[l] = LDS_LANE_DOWN;
        else
          fill_cnt_next[l] = fill_cnt_reg[l] + 3'h1;
      end
      lane_stat[l] = (lane_st_reg[l] == LDS_LANE_UP);
    end
  end

  // Transmit stuffing: absent lanes carry alternating fill words
  always_comb
  begin
    txw_next = txw_reg;
    fill_ph_next = fill_ph_reg;
    if (tx_word_valid)
    begin
      fill_ph_next = ~fill_ph_reg;
      for (int l = 0; l < 8; l++)
        txw_next[l*10 +: 10] = tx_lane_present[l] ? tx_lane_word_in[l*10 +: 10]
                               : (fill_ph_reg ? FILL_W1 : FILL_W0);
    end
  end

  // Pattern generators and checkers
  always_comb
  begin
    logic [2:0] hs, ls;
    logic       exp_b;
    hs = PAT_PRBS31;
    ls = PAT_PRBS31;
    exp_b = 1'b0;
    err_next = err_reg;
    for (int c = 0; c < 2; c++)
    begin
      hs = test_reg[c][2:0];
      ls = ls_sel(test_reg[c][2:0]);
      warm_next[c] = warm_reg[c];
      if (!test_en[c])
      begin
        gen_next[c] = pat_seed(hs);
        gen_next[c + 2] = pat_seed(ls);
        warm_next[c] = 5'h00;
        err_next[16 + c] = 1'b0;
        for (int l = 0; l < 8; l++)
          err_next[c*8 + l] = 1'b0;
      end
      else
      begin
        gen_next[c] = {gen_reg[c][29:0], pat_next(gen_reg[c], hs)};
        gen_next[c + 2] = {gen_reg[c + 2][29:0], pat_next(gen_reg[c + 2], ls)};
        if (warm_reg[c] != WARM_CYC)
          warm_next[c] = warm_reg[c] + 5'h01;
      end
      // Self-synchronising checks: history predicts the next bit
      hchk_next[c] = {hchk_reg[c][29:0], hs_rx_bit[c]};
      exp_b = pat_next(hchk_reg[c], hs);
      if (test_en[c] && warm_reg[c] == WARM_CYC && exp_b != hs_rx_bit[c])
        err_next[16 + c] = 1'b1;
      for (int l = 0; l < 8; l++)
      begin
        lchk_next[c*8 + l] = {lchk_reg[c*8 + l][29:0], ls_rx_bit[c*8 + l]};
        exp_b = pat_next(lchk_reg[c*8 + l], ls);
        if (test_en[c] && warm_reg[c] == WARM_CYC && exp_b != ls_rx_bit[c*8 + l])
          err_next[c*8 + l] = 1'b1;
      end
    end
  end

  // Pass pin routing and pin-side outputs
  always_comb
  begin
    logic       ch;
    logic [3:0] f;
    ch = pass_sel_reg[0][PASS_CH_BIT];
    f = pass_sel_reg[0][3:0];
    if (!test_en[ch])
      pass_next = 1'b1;
    else if (f[3])
      pass_next = ~err_reg[16 + ch];
    else
      pass_next = ~err_reg[{ch, f[2:0]}];
    for (int c = 0; c < 2; c++)
    begin
      // Optional conditions, all cleared after reset
      los_raw[c] = sig_loss[c]
                 | (losc_reg[c][SYNC_EN_BIT] & sync_lost[c])
                 | (losc_reg[c][PLL_EN_BIT] & pll_unlock[c])
                 | (losc_reg[c][DEC_EN_BIT] & dec_error[c])
                 | (losc_reg[c][AGC_EN_BIT] & ~adaptive_gain_locked[c])
                 | (losc_reg[c][AZ_EN_BIT] & ~autozero_cal_done[c]);
      los_next[c] = losc_reg[c][LOS_EN_BIT] & los_raw[c];
      oe_next[c] = ~pd[c];
      hbit_next[c] = gen_reg[c][0];
      lbit_next[c] = gen_reg[c + 2][0];
      eq_next[c] = losc_reg[c][EQ_EN_BIT];
      pre_next[c*4 +: 4] = deemph_reg[c][PRE_LSB +: 4];
      post_next[c*5 +: 5] = deemph_reg[c][POST_LSB +: 5];
    end
  end

  // State registers; fixed pipeline depth keeps latency constant
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 3; i++)
        pin_sy_reg[i] <= 3'h0;
      pin_reg <= 3'h0;
      for (int c = 0; c < 2; c++)
      begin
        pass_sel_reg[c] <= ZERO16;
        ctrl_reg[c] <= ZERO16;
        deemph_reg[c] <= ZERO16;
        test_reg[c] <= TEST_CTL_RST;
        losc_reg[c] <= ZERO16;
        warm_reg[c] <= 5'h00;
        hchk_reg[c] <= 31'h0000_0000;
      end
      for (int g = 0; g < 4; g++)
        gen_reg[g] <= {31{1'b1}};
      for (int l = 0; l < 16; l++)
        lchk_reg[l] <= 31'h0000_0000;
      for (int l = 0; l < 8; l++)
      begin
        lane_st_reg[l] <= LDS_LANE_UP;
        fill_cnt_reg[l] <= 3'h0;
      end
      rdata_reg <= ZERO16;
      rvalid_reg <= 1'b0;
      txw_reg <= 80'h0;
      fill_ph_reg <= 1'b0;
      err_reg <= 18'h0_0000;
      pass_reg <= 1'b1;
      los_reg <= 2'h0;
      oe_reg <= 2'h0;
      hbit_reg <= 2'h0;
      lbit_reg <= 2'h0;
      eq_reg <= 2'h0;
      pre_reg <= 8'h00;
      post_reg <= 10'h000;
    end
    else
    begin
      pin_sy_reg <= pin_sy_next;
      pin_reg <= pin_next;
      pass_sel_reg <= pass_sel_next;
      ctrl_reg <= ctrl_next;
      deemph_reg <= deemph_next;
      test_reg <= test_next;
      losc_reg <= losc_next;
      warm_reg <= warm_next;
      hchk_reg <= hchk_next;
      gen_reg <= gen_next;
      lchk_reg <= lchk_next;
      lane_st_reg <= lane_st_next;
      fill_cnt_reg <= fill_cnt_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      txw_reg <= txw_next;
      fill_ph_reg <= fill_ph_next;
      err_reg <= err_next;
      pass_reg <= pass_next;
      los_reg <= los_next;
      oe_reg <= oe_next;
      hbit_reg <= hbit_next;
      lbit_reg <= lbit_next;
      eq_reg <= eq_next;
      pre_reg <= pre_next;
      post_reg <= post_next;
    end
  end

  // Outputs straight from flops
  assign mgmt_rdata = rdata_reg;
  assign mgmt_rvalid = rvalid_reg;
  assign tx_lane_word_out = txw_reg;
  assign hs_tx_bit = hbit_reg;
  assign hs_tx_oe = oe_reg;
  assign ls_tx_bit = lbit_reg;
  assign ls_tx_oe = oe_reg;
  assign pattern_check_ok_pin = pass_reg;
  assign chan_a_signal_loss_out = los_reg[0];
  assign chan_b_signal_loss_out = los_reg[1];
  assign deemph_pre = pre_reg;
  assign deemph_post = post_reg;
  assign rx_eq_enable = eq_reg;

endmodule

//--- testbench/lds_far_end.sv
/*
  Far-end model of the remote aggregator: echoes the pattern lines back
  and sends eight lane words, fill words for lanes marked down.
  Assumes the bench steers error injection and lane state.
*/
`timescale 1ns/1ps
module lds_far_end
  import lds_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [3:0]  tx,
  input  wire logic [3:0]  oe,
  input  wire logic        flip,
  input  wire logic [7:0]  down_mask,
  output logic      [1:0]  hs_rx,
  output logic      [15:0] ls_rx,
  output logic      [79:0] word,
  output logic             valid
);
  logic [3:0] last_reg = 4'h0; // Level last seen on each line
  logic       ph_reg   = 1'b0; // Fill word phase
  logic [3:0] lvl;             // Line levels, released lines toggle
  // Remember levels and step the fill phase
  always_ff @(posedge clk)
  begin
    last_reg <= lvl;
    ph_reg   <= ~ph_reg;
  end
  // Loop back; flip corrupts every returned bit
  always_comb
  begin
    for (int c = 0; c < 4; c++)
      lvl[c] = oe[c] ? tx[c] : ~last_reg[c];
    hs_rx = lvl[1:0] ^ {2{flip}};
    ls_rx = {{8{lvl[3] ^ flip}}, {8{lvl[2] ^ flip}}};
    for (int l = 0; l < 8; l++)
      word[l*10+:10] = down_mask[l] ? (ph_reg ? FILL_W1 : FILL_W0) : 10'h0F0 + 10'(l);
  end
  assign valid = 1'b1;
endmodule

//--- testbench/lds_diag_props.sv
/*
  Checker for the diagnostic block ports.
  Assumes it is bound to the top module and shadows register writes.
*/
`timescale 1ns/1ps
module lds_diag_props
  import lds_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        pattern_test_enable_pin,
  input wire logic [1:0]  channel_powerdown_pin_n,
  input wire logic        mgmt_chan,
  input wire logic [4:0]  mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic        mgmt_wr,
  input wire logic        mgmt_rd,
  input wire logic [15:0] mgmt_rdata,
  input wire logic        mgmt_rvalid,
  input wire logic [1:0]  hs_tx_oe,
  input wire logic [1:0]  ls_tx_oe,
  input wire logic        pattern_check_ok_pin,
  input wire logic        chan_a_signal_loss_out,
  input wire logic [1:0]  sig_loss,
  input wire logic [7:0]  deemph_pre,
  input wire logic [9:0]  deemph_post,
  input wire logic [1:0]  rx_eq_enable
);
  logic [1:0][15:0] tc_reg, tc_next; // Test control shadow
  logic [1:0][15:0] lc_reg, lc_next; // Loss control shadow
  logic [15:0]      de_reg, de_next; // Bank A de-emphasis shadow
  logic [3:0]       qt_reg, qt_next; // Cycles with every test off
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Shadow next values
  always_comb
  begin
    tc_next = tc_reg;
    lc_next = lc_reg;
    de_next = de_reg;
    if (mgmt_wr && mgmt_addr == REG_TEST_CTL)
      tc_next[mgmt_chan] = mgmt_wdata;
    if (mgmt_wr && mgmt_addr == REG_LOS_CTL)
      lc_next[mgmt_chan] = mgmt_wdata;
    if (mgmt_wr && mgmt_addr == REG_DEEMPH && !mgmt_chan)
      de_next = mgmt_wdata;
    if (pattern_test_enable_pin || tc_reg[0][13:12] != 2'h0 || tc_reg[1][13:12] != 2'h0)
      qt_next = 4'h0;
    else
      qt_next = qt_reg + {3'h0, qt_reg != 4'h8};
  end
  // Shadow registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tc_reg <= {TEST_CTL_RST, TEST_CTL_RST};
      lc_reg <= '0;
      de_reg <= ZERO16;
      qt_reg <= 4'h0;
    end
    else
    begin
      tc_reg <= tc_next;
      lc_reg <= lc_next;
      de_reg <= de_next;
      qt_reg <= qt_next;
    end
  end
  a_read_answer: assert property (mgmt_rd |=> mgmt_rvalid)
    else $error("read not answered");
  a_rdata_idle: assert property (!mgmt_rvalid |-> mgmt_rdata == ZERO16)
    else $error("read data without valid");
  a_pass_idle: assert property (qt_reg == 4'h8 |-> pattern_check_ok_pin)
    else $error("pass pin low while tests off");
  a_oe_pin_pd: assert property (!channel_powerdown_pin_n[0] [*8] |-> !hs_tx_oe[0] && !ls_tx_oe[0])
    else $error("outputs driven in power-down");
  a_loss_gated: assert property (!lc_reg[0][LOS_EN_BIT] [*2] |-> !chan_a_signal_loss_out)
    else $error("loss output without enable");
  a_loss_raw: assert property (lc_reg[0][LOS_EN_BIT] [*2] ##0 sig_loss[0] |=> chan_a_signal_loss_out)
    else $error("loss output missed raw loss");
  a_eq_follow: assert property ($stable(lc_reg[0]) [*2] |-> rx_eq_enable[0] == lc_reg[0][EQ_EN_BIT])
    else $error("equalizer enable mismatch");
  a_deemph_fields: assert property ($stable(de_reg) [*2] |->
    deemph_pre[3:0] == de_reg[7:4] && deemph_post[4:0] == de_reg[12:8])
    else $error("de-emphasis field mismatch");
  c_read: cover property (mgmt_rvalid);
  c_pass_fail: cover property ($fell(pattern_check_ok_pin));
  c_loss: cover property ($rose(chan_a_signal_loss_out));
endmodule
bind lds_link_diag_status lds_diag_props i_props (.clk, .nrst, .pattern_test_enable_pin,
  .channel_powerdown_pin_n, .mgmt_chan, .mgmt_addr, .mgmt_wdata, .mgmt_wr, .mgmt_rd, .mgmt_rdata,
  .mgmt_rvalid, .hs_tx_oe, .ls_tx_oe, .pattern_check_ok_pin, .chan_a_signal_loss_out, .sig_loss,
  .deemph_pre, .deemph_post, .rx_eq_enable);

//--- testbench/lds_link_diag_status_tb.sv
/*
  Self-checking bench for the diagnostic block.
  Assumes the far-end model loops pattern lines back.
*/
`timescale 1ns/1ps
module lds_link_diag_status_tb
  import lds_pkg::*;
;
  logic        clk = 1'b0, nrst, pattern_test_enable_pin, mgmt_chan, mgmt_wr, mgmt_rd;
  logic        rx_word_valid, tx_word_valid, mgmt_rvalid, pattern_check_ok_pin, flip;
  logic        chan_a_signal_loss_out, chan_b_signal_loss_out;
  logic [1:0]  channel_powerdown_pin_n, hs_rx_bit, hs_tx_bit, hs_tx_oe, ls_tx_bit, ls_tx_oe;
  logic [1:0]  sig_loss, sync_lost, pll_unlock, dec_error, adaptive_gain_locked;
  logic [1:0]  autozero_cal_done, rx_eq_enable;
  logic [4:0]  mgmt_addr;
  logic [7:0]  tx_lane_present, down_mask, deemph_pre;
  logic [9:0]  deemph_post;
  logic [15:0] mgmt_wdata, ls_rx_bit, mgmt_rdata;
  logic [79:0] rx_lane_word, tx_lane_word_in, tx_lane_word_out;
  int          num_errors = 0, checked = 0;
  lds_link_diag_status i_dut (.clk, .nrst, .pattern_test_enable_pin, .channel_powerdown_pin_n,
    .mgmt_chan, .mgmt_addr, .mgmt_wdata, .mgmt_wr, .mgmt_rd, .rx_lane_word, .rx_word_valid,
    .tx_lane_word_in, .tx_lane_present, .tx_word_valid, .hs_rx_bit, .ls_rx_bit, .sig_loss,
    .sync_lost, .pll_unlock, .dec_error, .adaptive_gain_locked, .autozero_cal_done, .mgmt_rdata,
    .mgmt_rvalid, .tx_lane_word_out, .hs_tx_bit, .hs_tx_oe, .ls_tx_bit, .ls_tx_oe,
    .pattern_check_ok_pin, .chan_a_signal_loss_out, .chan_b_signal_loss_out, .deemph_pre,
    .deemph_post, .rx_eq_enable);
  lds_far_end i_far (.clk, .tx({ls_tx_bit, hs_tx_bit}), .oe({ls_tx_oe, hs_tx_oe}), .flip,
    .down_mask, .hs_rx(hs_rx_bit), .ls_rx(ls_rx_bit), .word(rx_lane_word), .valid(rx_word_valid));
  // Clock
  always #5 clk = ~clk;
  task automatic cmp(input logic [79:0] got, input logic [79:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One write strobe, then released
  task automatic mw(input logic ch, input logic [4:0] a, input logic [15:0] d);
    tick(1);
    mgmt_chan = ch;
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    tick(1);
    mgmt_wr = 1'b0;
  endtask
  // Read and compare; answer stands one cycle after the strobe edge
  task automatic rc(input logic ch, input logic [4:0] a, input logic [15:0] exp);
    tick(1);
    mgmt_chan = ch;
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    tick(1);
    mgmt_rd = 1'b0;
    cmp(mgmt_rvalid, 1'b1);
    cmp(mgmt_rdata, exp);
  endtask
  // Raise or clear one loss condition of channel A
  task automatic setc(input int k, input logic on);
    case (k)
      0: sig_loss[0] = on;
      1: sync_lost[0] = on;
      2: pll_unlock[0] = on;
      3: dec_error[0] = on;
      4: adaptive_gain_locked[0] = !on;
      default: autozero_cal_done[0] = !on;
    endcase
  endtask
  // Inject one corrupted bit, then look at the pass pin
  task automatic hit(input logic exp);
    flip = 1'b1;
    tick(1);
    flip = 1'b0;
    tick(8);
    cmp(pattern_check_ok_pin, exp);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #50000;
    num_errors++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    {nrst, pattern_test_enable_pin, mgmt_chan, mgmt_wr, mgmt_rd, tx_word_valid, flip} = '0;
    {mgmt_addr, mgmt_wdata, sig_loss, sync_lost, pll_unlock, dec_error} = '0;
    {adaptive_gain_locked, autozero_cal_done, channel_powerdown_pin_n} = '1;
    tx_lane_word_in = {8{10'h155}};
    tx_lane_present = 8'h0F;
    down_mask = 8'hA5;
    tick(10);
    nrst = 1'b1;
    tick(8);
    rc(1'b0, REG_TEST_CTL, TEST_CTL_RST);
    rc(1'b1, REG_LOS_CTL, ZERO16);
    rc(1'b0, 5'h1F, ZERO16);
    cmp({chan_b_signal_loss_out, chan_a_signal_loss_out, pattern_check_ok_pin}, 3'h1);
    cmp({ls_tx_oe, hs_tx_oe}, 4'hF);
    $display("reset values test done");
    rc(1'b0, REG_LANE_STAT, 16'h005A);
    mw(1'b0, REG_LANE_STAT, ZERO16);
    rc(1'b0, REG_LANE_STAT, 16'h005A);
    down_mask = 8'h00;
    rc(1'b0, REG_LANE_STAT, 16'h00FF);
    down_mask = 8'h80;
    rc(1'b0, REG_LANE_STAT, 16'h00FF);
    tick(4);
    rc(1'b0, REG_LANE_STAT, 16'h007F);
    tx_word_valid = 1'b1;
    tick(1);
    cmp(tx_lane_word_out, {{4{FILL_W0}}, {4{10'h155}}});
    tick(1);
    tx_word_valid = 1'b0;
    cmp(tx_lane_word_out, {{4{FILL_W1}}, {4{10'h155}}});
    $display("lane test done");
    mw(1'b0, REG_PASS_SEL, 16'h0008);
    for (int k = 0; k < 8; k++)
    begin
      mw(1'b0, REG_TEST_CTL, (k % 2 ? 16'h2000 : 16'h1000) + 16'(k));
      tick(64);
      cmp(pattern_check_ok_pin, 1'b1);
      // Low-speed lane 2 of channel A runs the mapped sequence
      mw(1'b0, REG_PASS_SEL, 16'h0002);
      tick(2);
      cmp(pattern_check_ok_pin, 1'b1);
      hit(1'b0);
      mw(1'b0, REG_PASS_SEL, 16'h0008);
      tick(2);
      cmp(pattern_check_ok_pin, 1'b0);
      mw(1'b0, REG_TEST_CTL, TEST_CTL_RST);
      tick(4);
      cmp(pattern_check_ok_pin, 1'b1);
    end
    mw(1'b0, REG_PASS_SEL, 16'h0003);
    pattern_test_enable_pin = 1'b1;
    tick(64);
    cmp(pattern_check_ok_pin, 1'b1);
    hit(1'b0);
    pattern_test_enable_pin = 1'b0;
    tick(8);
    cmp(pattern_check_ok_pin, 1'b1);
    mw(1'b1, REG_TEST_CTL, 16'h1002);
    mw(1'b0, REG_PASS_SEL, 16'h0008);
    tick(40);
    hit(1'b1);
    mw(1'b0, REG_PASS_SEL, 16'h0018);
    tick(2);
    cmp(pattern_check_ok_pin, 1'b0);
    mw(1'b1, REG_TEST_CTL, TEST_CTL_RST);
    $display("pattern test done");
    channel_powerdown_pin_n = 2'b10;
    tick(8);
    cmp({ls_tx_oe, hs_tx_oe}, 4'hA);
    channel_powerdown_pin_n = 2'b11;
    mw(1'b0, REG_CONTROL, 16'h8000);
    mw(1'b1, REG_CONTROL, 16'h8000);
    tick(2);
    cmp({ls_tx_oe, hs_tx_oe}, 4'h0);
    rc(1'b1, REG_TEST_CTL, TEST_CTL_RST);
    mw(1'b0, REG_CONTROL, ZERO16);
    mw(1'b1, REG_CONTROL, ZERO16);
    tick(8);
    cmp({ls_tx_oe, hs_tx_oe}, 4'hF);
    $display("power-down test done");
    for (int k = 0; k < 6; k++)
    begin
      setc(k, 1'b1);
      mw(1'b0, REG_LOS_CTL, 16'h0001);
      tick(3);
      cmp(chan_a_signal_loss_out, k == 0);
      rc(1'b0, REG_LOS_STAT, (16'h0001 << k) | (k == 0 ? 16'h0040 : ZERO16));
      mw(1'b0, REG_LOS_CTL, 16'h0001 | (16'h0001 << k));
      tick(3);
      cmp(chan_a_signal_loss_out, 1'b1);
      mw(1'b0, REG_LOS_CTL, (16'h0001 << k) & 16'hFFFE);
      tick(3);
      cmp(chan_a_signal_loss_out, 1'b0);
      setc(k, 1'b0);
    end
    sig_loss[1] = 1'b1;
    mw(1'b1, REG_LOS_CTL, 16'h0041);
    tick(3);
    // Bank B: equalizer on, loss on; bank A left without loss enable
    cmp({rx_eq_enable, chan_b_signal_loss_out, chan_a_signal_loss_out}, 4'hA);
    mw(1'b0, REG_DEEMPH, 16'h0A50);
    mw(1'b1, REG_DEEMPH, 16'h1F30);
    tick(2);
    cmp({deemph_post, deemph_pre}, {5'h1F, 5'h0A, 4'h3, 4'h5});
    $display("loss and driver test done");
    tally_and_finish();
  end
endmodule
